// ===== design/ddr_pkg.sv
package ddr_pkg;
  // ------------------------------------------------------------
  // Bus address and command encoding
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_FIXED = 3'h2;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [3:0] SEL_DAC0 = 4'h0;
  localparam logic [3:0] SEL_DAC1 = 4'h1;
  localparam logic [3:0] SEL_ALL = 4'hF;
  localparam logic [7:0] STORED_RESET = 8'h00;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BUSY_MS = 15;
  localparam int BUSY_CYCLES = BUSY_MS * (CLK_HZ / 1000);
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dac0;
    logic [7:0] dac1;
  } ddr_levels_t;
  typedef struct packed {
    logic [1:0] op;
    logic cmd_stored_select;
    logic cmd_working_select;
    logic [3:0] cmd_dac_select;
  } ddr_cmd_t;
endpackage : ddr_pkg

// ===== design/ddr_target.sv
module ddr_target #(
  parameter int BUSY_COUNT = ddr_pkg::BUSY_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [3:0] addr_strap_i,
  input wire logic mute_n_i,
  input wire logic [7:0] stored_init_i,
  output ddr_pkg::ddr_levels_t dac_output_o,
  output logic [1:0] dac_low_reference_o,
  output logic busy_o
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic [1:0] mute_meta;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  // Two flops each; only the second stage is read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      mute_meta <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
      mute_meta <= {mute_meta[0], mute_n_i};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign scl_s = scl_meta[1];
  assign sda_s = sda_meta[1];

  // ------------------------------------------------------------
  // Bus condition decode
  // ------------------------------------------------------------
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det = scl_s && scl_d && !sda_d && sda_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_READ,
    ST_SKIP
  } ddr_state_t;
  ddr_state_t state;
  ddr_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic in_ack;
  logic ack_drive;
  logic rw_read;
  ddr_pkg::ddr_cmd_t cmd;
  ddr_pkg::ddr_levels_t working_level_reg;
  ddr_pkg::ddr_levels_t stored_level_reg;
  logic nv_pending;
  logic [31:0] busy_cnt;
  logic [7:0] tx_byte;
  logic rd_en;

  // Address match: fixed 010 and straps, only while not busy (general call never matches)
  wire [6:0] own_addr = {ddr_pkg::ADDR_FIXED, addr_strap_i};
  wire addr_hit = (shreg[7:1] == own_addr) && !busy_o;
  wire byte_done = scl_rise && (bit_cnt == ddr_pkg::BIT_LAST);
  wire ack_rise = scl_rise && in_ack;
  wire [7:0] rx_byte = {shreg[6:0], sda_s};

  // Command field decode
  wire is_write = (cmd.op == ddr_pkg::CMD_WRITE);
  wire sel0 = (cmd.cmd_dac_select == ddr_pkg::SEL_DAC0);
  wire sel1 = (cmd.cmd_dac_select == ddr_pkg::SEL_DAC1);
  wire sel_all = (cmd.cmd_dac_select == ddr_pkg::SEL_ALL) && cmd.cmd_working_select
    && !cmd.cmd_stored_select;
  wire hit0 = sel0 || sel_all;
  wire hit1 = sel1 || sel_all;
  // Update strobe: rising edge that samples the last data bit (26th pulse)
  wire upd = (state == ST_DATA) && byte_done && is_write;
  wire wr_work = upd && cmd.cmd_working_select;
  wire wr_store = upd && cmd.cmd_stored_select && !sel_all;
  wire xfer = upd && !cmd.cmd_working_select && !cmd.cmd_stored_select;

  // Read data selection
  function automatic logic [7:0] pick(input ddr_pkg::ddr_levels_t lv, input logic s1);
    pick = s1 ? lv.dac1 : lv.dac0;
  endfunction : pick
  wire [7:0] rd_val = cmd.cmd_stored_select ? pick(stored_level_reg, sel1) :
    pick(working_level_reg, sel1);

  // ------------------------------------------------------------
  // Receiver state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (stop_det) begin
      next_state = ST_IDLE;
    end else if (start_det) begin
      next_state = ST_ADDR;
    end else if (ack_rise) begin
      unique case (state)
        ST_ADDR: next_state = !ack_drive ? ST_SKIP : (rw_read ? ST_READ : ST_CMD);
        ST_CMD: next_state = ack_drive ? ST_DATA : ST_SKIP;
        ST_DATA: next_state = ST_SKIP;
        ST_READ: next_state = sda_s ? ST_SKIP : ST_READ;
        ST_IDLE, ST_SKIP: next_state = state;
      endcase
    end
  end

  // Bit counter and shifter, nine clocks per byte
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || start_det || stop_det) begin
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
    end else if (scl_rise) begin
      shreg <= rx_byte;
      in_ack <= (bit_cnt == ddr_pkg::BIT_LAST);
      bit_cnt <= (bit_cnt == ddr_pkg::BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      rw_read <= 1'b0;
      cmd <= '0;
    end else begin
      state <= next_state;
      if (byte_done && state == ST_ADDR) begin
        rw_read <= sda_s;
      end
      if (byte_done && state == ST_CMD) begin
        cmd <= ddr_pkg::ddr_cmd_t'(rx_byte);
      end
    end
  end

  // Acknowledge and read data, changed on a falling SCL and cleared by a start or stop
  wire ack_ok = (state == ST_ADDR && addr_hit) || state == ST_CMD || state == ST_DATA;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || stop_det || start_det) begin
      ack_drive <= 1'b0;
      rd_en <= 1'b0;
      tx_byte <= 8'hFF;
    end else if (scl_fall) begin
      // Holding the acknowledge until the falling edge keeps it valid where the master samples
      ack_drive <= (bit_cnt == ddr_pkg::BIT_ACK) && ack_ok;
      rd_en <= (state == ST_READ) && (bit_cnt != ddr_pkg::BIT_ACK);
      if (state == ST_READ && bit_cnt == 4'h0) begin
        tx_byte <= rd_val;
      end else if (state == ST_READ && bit_cnt != ddr_pkg::BIT_ACK) begin
        tx_byte <= {tx_byte[6:0], 1'b1};
      end
    end
  end
  // Both drives change on a falling SCL or clear at a start or stop, so each bit stands through the whole high phase
  wire rd_drive = rd_en && !tx_byte[7];
  // Open drain: only low is driven
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_drive || rd_drive;

  // ------------------------------------------------------------
  // DAC registers
  // ------------------------------------------------------------
  // Stored image survives in the persistent domain; reset only reloads working copies
  logic loaded;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      working_level_reg <= '{dac0: ddr_pkg::WORKING_RESET, dac1: ddr_pkg::WORKING_RESET};
      loaded <= 1'b0;
    end else if (!loaded) begin
      working_level_reg <= stored_level_reg;
      loaded <= 1'b1;
    end else begin
      if (wr_work && hit0) working_level_reg.dac0 <= rx_byte;
      if (wr_work && hit1) working_level_reg.dac1 <= rx_byte;
      if (xfer && sel0) working_level_reg.dac0 <= stored_level_reg.dac0;
      if (xfer && sel1) working_level_reg.dac1 <= stored_level_reg.dac1;
    end
  end

  // Stored image is not cleared by reset: power loss is modelled by stored_init_i
  // Power-on value marks the first reset; later resets must not reload the stored image
  logic init_done = 1'b0;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      init_done <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!init_done && !rst_n_i) begin
      stored_level_reg <= '{dac0: stored_init_i, dac1: stored_init_i};
    end else if (wr_store && sel0) begin
      stored_level_reg.dac0 <= rx_byte;
    end else if (wr_store && sel1) begin
      stored_level_reg.dac1 <= rx_byte;
    end
  end

  // Busy window starts at the stop that ends a stored write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      nv_pending <= 1'b0;
      busy_cnt <= 32'h0;
    end else begin
      if (wr_store) nv_pending <= 1'b1;
      else if (stop_det || start_det) nv_pending <= 1'b0;
      if (stop_det && nv_pending) busy_cnt <= 32'(BUSY_COUNT);
      else if (busy_cnt != 32'h0) busy_cnt <= busy_cnt - 32'h1;
    end
  end
  assign busy_o = (busy_cnt != 32'h0);

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Mute gates the code to zero so the analog side sits at its low reference
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dac_output_o <= '0;
      dac_low_reference_o <= 2'h3;
    end else begin
      dac_output_o <= mute_meta[1] ? working_level_reg : '0;
      dac_low_reference_o <= {2{!mute_meta[1]}};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_mute;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !mute_meta[1] |=> dac_output_o == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("mute did not force low");
  property p_stop_idle;
    @(posedge clk_sys_i) disable iff (!rst_n_i) stop_det |=> state == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not to idle");
  property p_start_addr;
    @(posedge clk_sys_i) disable iff (!rst_n_i) start_det && !stop_det |=> state == ST_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start missed");
  property p_only_low;
    @(posedge clk_sys_i) disable iff (!rst_n_i) sda_oe_o |-> sda_o == 1'b0;
  endproperty
  a_only_low: assert property (p_only_low) else $error("sda driven high");
  property p_busy_nack;
    @(posedge clk_sys_i) disable iff (!rst_n_i) busy_o && state == ST_ADDR |-> !ack_drive;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
  property p_work_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i) loaded && wr_work && hit0 && !sel_all |=>
      working_level_reg.dac0 == $past(rx_byte);
  endproperty
  a_work_write: assert property (p_work_write) else $error("working write lost");
  property p_busy_start;
    @(posedge clk_sys_i) disable iff (!rst_n_i) stop_det && nv_pending |=> busy_o [*8];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not started");
  property p_no_gc;
    @(posedge clk_sys_i) disable iff (!rst_n_i) state == ST_ADDR && in_ack && shreg[7:1] == 7'h00 |-> !ack_drive;
  endproperty
  a_no_gc: assert property (p_no_gc) else $error("general call hit");
  property p_mute_ref;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !mute_meta[1] |=> dac_low_reference_o == 2'h3;
  endproperty
  a_mute_ref: assert property (p_mute_ref) else $error("mute did not select low reference");
  property p_ack_slot;
    @(posedge clk_sys_i) disable iff (!rst_n_i) ack_drive |-> bit_cnt == ddr_pkg::BIT_ACK || bit_cnt == 4'h0;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("acknowledge outside its slot");
  property p_abort;
    @(posedge clk_sys_i) disable iff (!rst_n_i) stop_det && state == ST_DATA |=> $stable(working_level_reg);
  endproperty
  a_abort: assert property (p_abort) else $error("aborted write changed a register");
  property p_idle_release;
    @(posedge clk_sys_i) disable iff (!rst_n_i) state == ST_IDLE |-> !sda_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data line held while idle");
  property p_hold_high;
    @(posedge clk_sys_i) disable iff (!rst_n_i) scl_s && scl_d |-> $stable(sda_oe_o);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data drive moved while clock high");
  property p_xfer_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i) loaded && xfer && sel1 |=>
      working_level_reg.dac1 == $past(stored_level_reg.dac1);
  endproperty
  a_xfer_load: assert property (p_xfer_load) else $error("transfer from stored lost");
  property p_store_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i) wr_store && sel1 |=> stored_level_reg.dac1 == $past(rx_byte);
  endproperty
  a_store_write: assert property (p_store_write) else $error("stored write lost");
  property p_read_nack;
    @(posedge clk_sys_i) disable iff (!rst_n_i) ack_rise && state == ST_READ && sda_s |=> state == ST_SKIP;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("read went on after not-acknowledge");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  c_write: cover property (@(posedge clk_sys_i) wr_work);
  c_store: cover property (@(posedge clk_sys_i) wr_store);
  c_read: cover property (@(posedge clk_sys_i) state == ST_READ);
  c_xfer: cover property (@(posedge clk_sys_i) xfer);
  c_busy_nack: cover property (@(posedge clk_sys_i) busy_o && state == ST_ADDR && in_ack);
endmodule : ddr_target

// ===== testbench/ddr_master.sv
module ddr_master #(
  parameter int HALF = 42
) (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Two-wire master model, both lines idle high
  // ------------------------------------------------------------
  // Three phases of HALF cycles per bit keep SCL at 400 kHz or below
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Lines move just after a system clock edge
  task automatic tick();
    repeat (HALF) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // Start, also used as a repeated start from a low SCL
  task automatic start_cond();
    sda_oe_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask : start_cond
  task automatic stop_cond();
    sda_oe_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b0;
    tick();
  endtask : stop_cond
  // Data changes only while SCL is low and is sampled late in the high phase
  task automatic bit_xfer(input logic pull_low, output logic seen);
    sda_oe_o = pull_low;
    tick();
    scl_o = 1'b1;
    tick();
    seen = sda_i;
    scl_o = 1'b0;
    tick();
  endtask : bit_xfer
  task automatic write_byte(input logic [7:0] val, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(~val[i], s);
    end
    bit_xfer(1'b0, s);
    ack = ~s;
  endtask : write_byte
  // Always ends with a not-acknowledge, so only single-byte reads
  task automatic read_byte(output logic [7:0] val);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b0, s);
      val[i] = s;
    end
    bit_xfer(1'b0, s);
  endtask : read_byte
endmodule : ddr_master

// ===== testbench/ddr_target_tb.sv
module ddr_target_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] STRAP = 4'hA;
  localparam logic [6:0] DEV = {ddr_pkg::ADDR_FIXED, STRAP};
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mute_n_i = 1'b1;
  logic scl, m_oe, t_oe, t_sda;
  logic [1:0] low_ref;
  logic busy;
  logic a0, a1, a2;
  logic [7:0] rd;
  ddr_pkg::ddr_levels_t levels;
  wire logic sda_line;
  int errors = 0;
  int num_checks = 0;
  // ------------------------------------------------------------
  // Clock, pulled-up data line, instances
  // ------------------------------------------------------------
  always #10 clk_sys_i = ~clk_sys_i;
  assign sda_line = ~(m_oe | t_oe);
  ddr_master ddr_master_inst (.clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(m_oe));
  // Short busy window keeps the run brief but outlasts one address byte
  ddr_target #(.BUSY_COUNT(2000)) ddr_target_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(t_sda), .sda_oe_o(t_oe), .addr_strap_i(STRAP), .mute_n_i(mute_n_i),
    .stored_init_i(8'h00), .dac_output_o(levels), .dac_low_reference_o(low_ref), .busy_o(busy));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask : do_reset
  task automatic write_cmd(input logic [7:0] cmd, input logic [7:0] data);
    ddr_master_inst.start_cond();
    ddr_master_inst.write_byte({DEV, 1'b0}, a0);
    ddr_master_inst.write_byte(cmd, a1);
    ddr_master_inst.write_byte(data, a2);
    ddr_master_inst.stop_cond();
    check("write acks", {13'h0000, a0, a1, a2}, 16'h0007);
  endtask : write_cmd
  task automatic read_cmd(input logic [7:0] cmd, input logic [7:0] exp);
    ddr_master_inst.start_cond();
    ddr_master_inst.write_byte({DEV, 1'b0}, a0);
    ddr_master_inst.write_byte(cmd, a1);
    ddr_master_inst.start_cond();
    ddr_master_inst.write_byte({DEV, 1'b1}, a2);
    ddr_master_inst.read_byte(rd);
    ddr_master_inst.stop_cond();
    check("read acks", {13'h0000, a0, a1, a2}, 16'h0007);
    check("read data", {8'h00, rd}, {8'h00, exp});
  endtask : read_cmd
  // Address only, expected to go unanswered
  task automatic probe(input logic [7:0] addr_byte);
    ddr_master_inst.start_cond();
    ddr_master_inst.write_byte(addr_byte, a0);
    ddr_master_inst.stop_cond();
    check("no ack", 16'(a0), 16'h0000);
  endtask : probe
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    check("reset levels", levels, 16'h0000);
    write_cmd(8'h10, 8'hA5);
    check("write dac0", levels, 16'hA500);
    write_cmd(8'h1F, 8'h3C);
    check("write all", levels, 16'h3C3C);
    write_cmd(8'h21, 8'h5A);
    check("busy after stored write", 16'(busy), 16'h0001);
    probe({DEV, 1'b0});
    check("stored write keeps output", levels, 16'h3C3C);
    for (int i = 0; i <= 3000; i++) begin
      if (busy === 1'b0) begin
        break;
      end
      if (i == 3000) begin
        errors++;
        end_of_test();
      end
      @(posedge clk_sys_i);
      #1;
    end
    read_cmd(8'hA1, 8'h5A);
    read_cmd(8'h90, 8'h3C);
    write_cmd(8'h01, 8'h00);
    check("transfer dac1", levels, 16'h3C5A);
    probe({ddr_pkg::ADDR_FIXED, ~STRAP, 1'b0});
    probe(8'h00);
    // Write abandoned mid data byte by a stop
    ddr_master_inst.start_cond();
    ddr_master_inst.write_byte({DEV, 1'b0}, a0);
    ddr_master_inst.write_byte(8'h10, a1);
    for (int i = 0; i < 4; i++) begin
      ddr_master_inst.bit_xfer(1'b0, a2);
    end
    ddr_master_inst.stop_cond();
    check("aborted write", levels, 16'h3C5A);
    write_cmd(8'h10, 8'h81);
    check("write after abort", levels, 16'h815A);
    mute_n_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1;
    check("muted levels", levels, 16'h0000);
    check("muted low ref", {14'h0000, low_ref}, 16'h0003);
    mute_n_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    check("unmuted levels", levels, 16'h815A);
    check("unmuted low ref", {14'h0000, low_ref}, 16'h0000);
    check("sda value", 16'(t_sda), 16'h0000);
    do_reset();
    check("levels after reset", levels, 16'h005A);
    end_of_test();
  end
endmodule : ddr_target_tb
